//--- port_timer_ctrl_pkg.sv
// Summary of operation
// RULE1 - Pair A bit chains timers 0,1 16-bit
// RULE2 - Pair B bit chains timers 2,3 16-bit
// RULE3 - Filter enable for external clock input 0
// RULE4 - Filter enable for external clock input 1
// RULE5 - Per-timer pin output enable, reset off
// RULE6 - Timers 2,3 inverted output enables, reset off
// RULE7 - D0 selects external or internal clock
// RULE8 - Three-bit divided clock source and divider
// RULE9 - Port 2 Schmitt input select, reset 0
// RULE10 - Port 2 pull-up enable per pin
// RULE11 - Clock timer run bit at D0
// RULE12 - Higher timer wins shared pin; chained hides lower
// RULE13 - Preset and restart bits are write strobes
// RULE14 - Unused bits read 0; reserved bit stored
package port_timer_ctrl_pkg;
    localparam logic [15:0] PairACtrl0Addr = 16'hFF30;
    localparam logic [15:0] PairACtrl1Addr = 16'hFF31;
    localparam logic [15:0] PairBCtrl0Addr = 16'hFF38;
    localparam logic [15:0] PairBCtrl1Addr = 16'hFF39;
    localparam logic [15:0] WdogClkoutAddr = 16'hFF40;
    localparam logic [15:0] PullupAddr = 16'hFF6C;
    localparam logic [15:0] LevelSelAddr = 16'hFF6E;
    localparam int ChainBit = 7;
    localparam int FilterBit = 6;
    localparam int ReservedBit = 4;
    localparam int InvOutBit = 4;
    localparam int PinOutBit = 3;
    localparam int RunBit = 2;
    localparam int PresetBit = 1;
    localparam int SourceBit = 0;
    localparam int WdogEnBit = 7;
    localparam int DivSelLsb = 4;
    localparam int DivPinBit = 3;
    localparam int WdogRestartBit = 2;
    localparam int ClkTimerClearBit = 1;
    localparam int ClkTimerRunBit = 0;
    localparam logic [7:0] TimerCtrlRst = 8'h00;
    localparam logic [7:0] WdogClkoutRst = 8'h80;
    localparam logic [7:0] LevelSelRst = 8'h00;
    localparam logic [7:0] PullupRst = 8'hFF;
    localparam logic [7:0] PairA0Mask = 8'hDD;
    localparam logic [7:0] PairA1Mask = 8'h1D;
    localparam logic [7:0] PairB0Mask = 8'hDD;
    localparam logic [7:0] PairB1Mask = 8'h1D;
    localparam logic [7:0] WdogClkoutMask = 8'hF9;
    localparam logic [7:0] StrobeMask = 8'h02;
    localparam logic [7:0] WdogStrobeMask = 8'h06;
endpackage

//--- ctrl_reg_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ctrl_reg_if;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic [7:0] value;
    modport owner(input addr, input wdata, input wr, output value);
    modport user(output addr, output wdata, output wr, input value);
endinterface
`default_nettype wire

//--- ctrl_reg.sv
`timescale 1ns/1ns
`default_nettype none
module ctrl_reg #(
    parameter logic [15:0] Addr = 16'h0000,
    parameter logic [7:0] ResetVal = 8'h00,
    parameter logic [7:0] StoreMask = 8'hFF,
    parameter logic [7:0] PulseMask = 8'h00
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    ctrl_reg_if.owner bus,
    output logic [7:0] pulse
);
    logic [7:0] value_q;
    logic [7:0] pulse_q;
    wire hit = bus.wr && (bus.addr == Addr);
    // Unused bits never store, so they read 0  (see RULE14)
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            value_q <= ResetVal & StoreMask;
        end else if (hit) begin
            value_q <= bus.wdata & StoreMask;
        end
    end
    // One-cycle action on written 1, nothing on 0  (see RULE13)
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pulse_q <= 8'h00;
        end else begin
            pulse_q <= hit ? (bus.wdata & PulseMask) : 8'h00;
        end
    end
    assign bus.value = value_q;
    assign pulse = pulse_q;
endmodule
`default_nettype wire

//--- port_timer_output_ctrl_bits.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module port_timer_output_ctrl_bits
    import port_timer_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [15:0] busAddr,
    input wire logic [7:0] busWdata,
    input wire logic busWr,
    input wire logic busRd,
    output logic [7:0] busRdata,
    output logic pair_a_chain_select,
    output logic pair_b_chain_select,
    output logic ext_clk0_filter_enable,
    output logic ext_clk1_filter_enable,
    output logic [3:0] timerRun,
    output logic [3:0] timerSourceSelect,
    output logic [3:0] timerPresetStrobe,
    output logic [3:0] timerPinOutputEnable,
    output logic timer2_inverted_output_enable,
    output logic timer3_inverted_output_enable,
    output logic port14TimerOut,
    output logic port14UseTimer1,
    output logic port15TimerOut,
    output logic port15UseTimer3,
    output logic port17InvTimerOut,
    output logic port17UseTimer3,
    output logic [2:0] divclkSelect,
    output logic divclk_pin_enable,
    output logic watchdog_enable_bit,
    output logic watchdog_restart_strobe,
    output logic clock_timer_clear_strobe,
    output logic clock_timer_run_bit,
    output logic [7:0] port2SchmittSelect,
    output logic [7:0] port2PullupEnable
);
    ctrl_reg_if a0();
    ctrl_reg_if a1();
    ctrl_reg_if b0();
    ctrl_reg_if b1();
    ctrl_reg_if wc();
    ctrl_reg_if lv();
    ctrl_reg_if pu();
    logic [7:0] pA0;
    logic [7:0] pA1;
    logic [7:0] pB0;
    logic [7:0] pB1;
    logic [7:0] pWc;

    assign a0.addr = busAddr;
    assign a0.wdata = busWdata;
    assign a0.wr = busWr;
    assign a1.addr = busAddr;
    assign a1.wdata = busWdata;
    assign a1.wr = busWr;
    assign b0.addr = busAddr;
    assign b0.wdata = busWdata;
    assign b0.wr = busWr;
    assign b1.addr = busAddr;
    assign b1.wdata = busWdata;
    assign b1.wr = busWr;
    assign wc.addr = busAddr;
    assign wc.wdata = busWdata;
    assign wc.wr = busWr;
    assign lv.addr = busAddr;
    assign lv.wdata = busWdata;
    assign lv.wr = busWr;
    assign pu.addr = busAddr;
    assign pu.wdata = busWdata;
    assign pu.wr = busWr;

    ctrl_reg #(.Addr(PairACtrl0Addr), .ResetVal(TimerCtrlRst), .StoreMask(PairA0Mask),
        .PulseMask(StrobeMask)) uA0 (.core_clk(core_clk), .sys_rst(sys_rst), .bus(a0),
        .pulse(pA0));
    ctrl_reg #(.Addr(PairACtrl1Addr), .ResetVal(TimerCtrlRst), .StoreMask(PairA1Mask),
        .PulseMask(StrobeMask)) uA1 (.core_clk(core_clk), .sys_rst(sys_rst), .bus(a1),
        .pulse(pA1));
    ctrl_reg #(.Addr(PairBCtrl0Addr), .ResetVal(TimerCtrlRst), .StoreMask(PairB0Mask),
        .PulseMask(StrobeMask)) uB0 (.core_clk(core_clk), .sys_rst(sys_rst), .bus(b0),
        .pulse(pB0));
    ctrl_reg #(.Addr(PairBCtrl1Addr), .ResetVal(TimerCtrlRst), .StoreMask(PairB1Mask),
        .PulseMask(StrobeMask)) uB1 (.core_clk(core_clk), .sys_rst(sys_rst), .bus(b1),
        .pulse(pB1));
    ctrl_reg #(.Addr(WdogClkoutAddr), .ResetVal(WdogClkoutRst), .StoreMask(WdogClkoutMask),
        .PulseMask(WdogStrobeMask)) uWc (.core_clk(core_clk), .sys_rst(sys_rst), .bus(wc),
        .pulse(pWc));
    // Schmitt select per port 2 pin  (see RULE9)
    ctrl_reg #(.Addr(LevelSelAddr), .ResetVal(LevelSelRst), .StoreMask(8'hFF),
        .PulseMask(8'h00)) uLv (.core_clk(core_clk), .sys_rst(sys_rst), .bus(lv),
        .pulse());
    // Pull-up per port 2 pin, on after reset  (see RULE10)
    ctrl_reg #(.Addr(PullupAddr), .ResetVal(PullupRst), .StoreMask(8'hFF),
        .PulseMask(8'h00)) uPu (.core_clk(core_clk), .sys_rst(sys_rst), .bus(pu),
        .pulse());

    wire [7:0] rA0 = a0.value;
    wire [7:0] rA1 = a1.value;
    wire [7:0] rB0 = b0.value;
    wire [7:0] rB1 = b1.value;
    wire [7:0] rWc = wc.value;
    wire [7:0] rLv = lv.value;
    wire [7:0] rPu = pu.value;

    // Unmapped addresses answer 0; strobe bits never stored  (see RULE14)
    wire [7:0] readMux =
        (busAddr == PairACtrl0Addr) ? rA0 :
        (busAddr == PairACtrl1Addr) ? rA1 :
        (busAddr == PairBCtrl0Addr) ? rB0 :
        (busAddr == PairBCtrl1Addr) ? rB1 :
        (busAddr == WdogClkoutAddr) ? rWc :
        (busAddr == LevelSelAddr) ? rLv :
        (busAddr == PullupAddr) ? rPu : 8'h00;

    wire chainA = rA0[ChainBit]; // see RULE1
    wire chainB = rB0[ChainBit]; // see RULE2
    wire [3:0] pinEn = {rB1[PinOutBit], rB0[PinOutBit], rA1[PinOutBit], rA0[PinOutBit]};
    // Higher timer wins the pin; chained pair hides lower output  (see RULE12)
    wire p14On = pinEn[1] || (pinEn[0] && !chainA);
    wire p14Sel1 = pinEn[1] || chainA;
    wire p15On = pinEn[3] || (pinEn[2] && !chainB);
    wire p15Sel3 = pinEn[3] || chainB;
    wire inv3 = rB1[InvOutBit];
    wire inv2 = rB0[InvOutBit];
    wire p17On = inv3 || (inv2 && !chainB); // see RULE6
    wire p17Sel3 = inv3 || chainB;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            busRdata <= 8'h00;
        end else begin
            busRdata <= busRd ? readMux : 8'h00;
        end
    end

    // Outputs registered once more so each leaves a flip-flop
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pair_a_chain_select <= 1'b0;
            pair_b_chain_select <= 1'b0;
            ext_clk0_filter_enable <= 1'b0;
            ext_clk1_filter_enable <= 1'b0;
            timerRun <= 4'h0;
            timerSourceSelect <= 4'h0;
            timerPinOutputEnable <= 4'h0;
            timer2_inverted_output_enable <= 1'b0;
            timer3_inverted_output_enable <= 1'b0;
            port14TimerOut <= 1'b0;
            port14UseTimer1 <= 1'b0;
            port15TimerOut <= 1'b0;
            port15UseTimer3 <= 1'b0;
            port17InvTimerOut <= 1'b0;
            port17UseTimer3 <= 1'b0;
            divclkSelect <= 3'h0;
            divclk_pin_enable <= 1'b0;
            watchdog_enable_bit <= WdogClkoutRst[WdogEnBit];
            clock_timer_run_bit <= 1'b0;
            port2SchmittSelect <= LevelSelRst;
            port2PullupEnable <= PullupRst;
        end else begin
            pair_a_chain_select <= chainA; // see RULE1
            pair_b_chain_select <= chainB; // see RULE2
            ext_clk0_filter_enable <= rA0[FilterBit]; // see RULE3
            ext_clk1_filter_enable <= rB0[FilterBit]; // see RULE4
            timerRun <= {rB1[RunBit], rB0[RunBit], rA1[RunBit], rA0[RunBit]};
            timerSourceSelect <= {rB1[SourceBit], rB0[SourceBit], rA1[SourceBit],
                rA0[SourceBit]}; // see RULE7
            timerPinOutputEnable <= pinEn; // see RULE5
            timer2_inverted_output_enable <= inv2; // see RULE6
            timer3_inverted_output_enable <= inv3;
            port14TimerOut <= p14On; // see RULE12
            port14UseTimer1 <= p14Sel1;
            port15TimerOut <= p15On;
            port15UseTimer3 <= p15Sel3;
            port17InvTimerOut <= p17On;
            port17UseTimer3 <= p17Sel3;
            divclkSelect <= rWc[DivSelLsb +: 3]; // see RULE8
            divclk_pin_enable <= rWc[DivPinBit];
            watchdog_enable_bit <= rWc[WdogEnBit];
            clock_timer_run_bit <= rWc[ClkTimerRunBit]; // see RULE11
            port2SchmittSelect <= rLv; // see RULE9
            port2PullupEnable <= rPu; // see RULE10
        end
    end

    // Pulses already leave flip-flops inside the register blocks
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            timerPresetStrobe <= 4'h0;
            watchdog_restart_strobe <= 1'b0;
            clock_timer_clear_strobe <= 1'b0;
        end else begin
            timerPresetStrobe <= {pB1[PresetBit], pB0[PresetBit], pA1[PresetBit],
                pA0[PresetBit]}; // see RULE13
            watchdog_restart_strobe <= pWc[WdogRestartBit];
            clock_timer_clear_strobe <= pWc[ClkTimerClearBit];
        end
    end
endmodule
`default_nettype wire

//--- port_timer_output_ctrl_bits_chk.sv
`timescale 1ns/1ns
`default_nettype none
module port_timer_output_ctrl_bits_chk
    import port_timer_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [15:0] busAddr,
    input wire logic [7:0] busWdata,
    input wire logic busWr,
    input wire logic busRd,
    input wire logic [7:0] busRdata,
    input wire logic [3:0] timerPresetStrobe,
    input wire logic watchdog_restart_strobe,
    input wire logic pair_a_chain_select,
    input wire logic pair_b_chain_select,
    input wire logic [7:0] port2PullupEnable,
    input wire logic [7:0] port2SchmittSelect,
    input wire logic [2:0] divclkSelect,
    input wire logic [3:0] timerPinOutputEnable,
    input wire logic port14TimerOut,
    input wire logic port14UseTimer1,
    input wire logic port15TimerOut
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    read_idle_a: assert property (busRdata != 8'h00 |-> $past(busRd))
        else $error("Read data outside read slot");
    preset_pulse_a: assert property (busWr && busAddr == PairBCtrl1Addr && busWdata[1]
        |-> ##2 timerPresetStrobe[3]) else $error("Preset pulse missing");
    restart_cause_a: assert property (watchdog_restart_strobe |-> $past(busWr, 2)
        && $past(busAddr, 2) == WdogClkoutAddr && ($past(busWdata, 2) & 8'h04) != 8'h00)
        else $error("Restart pulse without write");
    chain_follow_a: assert property (busWr && busAddr == PairACtrl0Addr
        |-> ##2 {7'h00, pair_a_chain_select} == ($past(busWdata, 2) >> 7))
        else $error("Chain bit wrong");
    pullup_follow_a: assert property (busWr && busAddr == PullupAddr
        |-> ##2 port2PullupEnable == $past(busWdata, 2)) else $error("Pull-up wrong");
    level_hold_a: assert property ($changed(port2SchmittSelect) |-> $past(busWr, 2)
        && $past(busAddr, 2) == LevelSelAddr) else $error("Level select moved");
    divsel_follow_a: assert property (busWr && busAddr == WdogClkoutAddr
        |-> ##2 {1'b0, divclkSelect, 4'h0} == ($past(busWdata, 2) & 8'h70))
        else $error("Divider select wrong");
    pin14_priority_a: assert property (timerPinOutputEnable[1]
        |-> port14TimerOut && port14UseTimer1) else $error("Timer 1 lost pin");
    chain_hide_a: assert property (pair_b_chain_select && !timerPinOutputEnable[3]
        |-> !port15TimerOut) else $error("Lower timer shown in chain");
endmodule
bind port_timer_output_ctrl_bits port_timer_output_ctrl_bits_chk i_chk (.core_clk, .sys_rst,
    .busAddr, .busWdata, .busWr, .busRd, .busRdata, .timerPresetStrobe, .watchdog_restart_strobe,
    .pair_a_chain_select, .pair_b_chain_select, .port2PullupEnable, .port2SchmittSelect,
    .divclkSelect, .timerPinOutputEnable, .port14TimerOut, .port14UseTimer1, .port15TimerOut);
`default_nettype wire

//--- port_timer_output_ctrl_bits_tb.sv
`timescale 1ns/1ns
`default_nettype none
module port_timer_output_ctrl_bits_tb;
    import port_timer_ctrl_pkg::*;
    logic core_clk = 1'b0, sys_rst = 1'b1, busWr = 1'b0, busRd = 1'b0;
    logic [15:0] busAddr = 16'h0000;
    logic [7:0] busWdata = 8'h00, busRdata, port2SchmittSelect, port2PullupEnable;
    logic pair_a_chain_select, pair_b_chain_select, ext_clk0_filter_enable, ext_clk1_filter_enable;
    logic timer2_inverted_output_enable, timer3_inverted_output_enable, divclk_pin_enable;
    logic port14TimerOut, port14UseTimer1, port15TimerOut, port15UseTimer3;
    logic port17InvTimerOut, port17UseTimer3, watchdog_enable_bit, watchdog_restart_strobe;
    logic clock_timer_clear_strobe, clock_timer_run_bit;
    logic [3:0] timerRun, timerSourceSelect, timerPresetStrobe, timerPinOutputEnable;
    logic [2:0] divclkSelect;
    int n_mismatch = 0, checks = 0, cycles = 0;
    logic [15:0] addrs [8] = '{16'hFF30, 16'hFF31, 16'hFF38, 16'hFF39, 16'hFF40, 16'hFF6C,
        16'hFF6E, 16'hFF50};
    logic [7:0] rstVals [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'hFF, 8'h00, 8'h00};
    logic [7:0] oneVals [8] = '{8'hDD, 8'h1D, 8'hDD, 8'h1D, 8'hF9, 8'hFF, 8'hFF, 8'h00};
    wire logic [22:0] ctrlVec = {pair_a_chain_select, pair_b_chain_select,
        ext_clk0_filter_enable, ext_clk1_filter_enable, timerRun, timerSourceSelect,
        timerPinOutputEnable, timer2_inverted_output_enable, timer3_inverted_output_enable,
        divclkSelect, divclk_pin_enable, watchdog_enable_bit, clock_timer_run_bit};
    wire logic [15:0] port2Vec = {port2SchmittSelect, port2PullupEnable};
    port_timer_output_ctrl_bits i_port_timer_output_ctrl_bits (.core_clk, .sys_rst, .busAddr,
        .busWdata, .busWr, .busRd, .busRdata, .pair_a_chain_select, .pair_b_chain_select,
        .ext_clk0_filter_enable, .ext_clk1_filter_enable, .timerRun, .timerSourceSelect,
        .timerPresetStrobe, .timerPinOutputEnable, .timer2_inverted_output_enable,
        .timer3_inverted_output_enable, .port14TimerOut, .port14UseTimer1, .port15TimerOut,
        .port15UseTimer3, .port17InvTimerOut, .port17UseTimer3, .divclkSelect,
        .divclk_pin_enable, .watchdog_enable_bit, .watchdog_restart_strobe,
        .clock_timer_clear_strobe, .clock_timer_run_bit, .port2SchmittSelect, .port2PullupEnable);
    always #50 core_clk = ~core_clk;
    task automatic give_verdict();
        if (n_mismatch == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Whole run is about 115 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        busWr <= 1'b1;
        busAddr <= a;
        busWdata <= d;
        @(posedge core_clk);
        busWr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        busRd <= 1'b1;
        busAddr <= a;
        @(posedge core_clk);
        busRd <= 1'b0;
        #1;
        check($sformatf("read %h", a), {24'h0, busRdata}, {24'h0, exp});
    endtask
    // Controls land one edge after the write edge; wait two to be sure
    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        check("controls", {9'h0, ctrlVec}, 32'h2);
        check("port2", {16'h0, port2Vec}, 32'hFF);
        for (int i = 0; i < 8; i++) rd(addrs[i], rstVals[i]);
        for (int i = 0; i < 8; i++) begin
            wr(addrs[i], 8'hFF);
            rd(addrs[i], oneVals[i]);
        end
        settle();
        check("controls", {9'h0, ctrlVec}, 32'h7FFFFF);
        check("pins", {26'h0, port14TimerOut, port14UseTimer1, port15TimerOut, port15UseTimer3,
            port17InvTimerOut, port17UseTimer3}, 32'h3F);
        check("port2", {16'h0, port2Vec}, 32'hFFFF);
        for (int i = 0; i < 8; i++) begin
            wr(addrs[i], 8'h00);
            rd(addrs[i], 8'h00);
        end
        settle();
        check("controls", {9'h0, ctrlVec}, 32'h0);
        check("port2", {16'h0, port2Vec}, 32'h0);
        wr(PairBCtrl0Addr, 8'h98);
        settle();
        check("chained pins", {30'h0, port15TimerOut, port17InvTimerOut}, 32'h0);
        wr(PairACtrl0Addr, 8'h08);
        settle();
        check("pin 14", {30'h0, port14TimerOut, port14UseTimer1}, 32'h2);
        wr(PairACtrl1Addr, 8'h08);
        settle();
        check("pin 14", {30'h0, port14TimerOut, port14UseTimer1}, 32'h3);
        wr(LevelSelAddr, 8'hA5);
        wr(PullupAddr, 8'h5A);
        settle();
        check("port2", {16'h0, port2Vec}, 32'hA55A);
        // Strobes stand for one cycle only, so look in that cycle and the next
        wr(PairACtrl0Addr, 8'h02);
        @(posedge core_clk);
        #1;
        check("preset", {28'h0, timerPresetStrobe}, 32'h1);
        @(posedge core_clk);
        #1;
        check("preset end", {28'h0, timerPresetStrobe}, 32'h0);
        wr(WdogClkoutAddr, 8'h06);
        @(posedge core_clk);
        #1;
        check("restarts", {30'h0, watchdog_restart_strobe, clock_timer_clear_strobe},
            32'h3);
        @(posedge core_clk);
        #1;
        check("restarts end", {30'h0, watchdog_restart_strobe, clock_timer_clear_strobe},
            32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
